// >>> rtl/rsc_pclk_div.sv
// Peripheral clock divider producing a tick at the chosen ratio
`timescale 1ns/10ps
module rsc_pclk_div
   import rsc_pkg::*;
#(
   parameter int CNT_W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Requested ratio, never the reserved code
   input wire logic [1:0] ratio,
   // Divided clock enable and ratio in force
   output logic pclk_tick,
   output logic [1:0] active
);

   initial begin
      if (CNT_W < 2) begin
         $error("rsc_pclk_div: CNT_W must be at least 2");
      end
   end

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0] next_active;
   logic next_tick;

   // New ratio only at a period end, so no short pulse escapes
   always_comb begin
      next_cnt = cnt + 1'b1;
      next_active = active;
      next_tick = 1'b0;
      if (cnt == CNT_W'(rsc_ratio_last(active))) begin
         next_cnt = '0;
         next_active = ratio;
         next_tick = 1'b1;
      end
   end

   // Runs straight off the processor clock, held frozen while ce is low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
         active <= RATIO_RESET;
         pclk_tick <= 1'b0;
      end else if (ce) begin
         cnt <= next_cnt;
         active <= next_active;
         pclk_tick <= next_tick;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_tick_at_wrap: assert property (pclk_tick |-> cnt == '0)
      else $error("peripheral tick away from period start");
   a_ratio_boundary: assert property ($changed(active) |->
      $past(cnt) == CNT_W'(rsc_ratio_last($past(active))))
      else $error("ratio changed inside a period");

endmodule

// >>> rtl/rsc_pkg.sv
// Shared constants and types for the reset sequencer and clock divider
package rsc_pkg;

   // Register addresses on the peripheral bus
   localparam logic [31:0] ADDR_RATIO = 32'he01fc100;
   localparam logic [31:0] ADDR_FLAGS = 32'he01fc180;
   localparam int REG_W = 8;

   // Peripheral clock ratio codes
   localparam logic [1:0] RATIO_QUARTER = 2'h0;
   localparam logic [1:0] RATIO_FULL = 2'h1;
   localparam logic [1:0] RATIO_HALF = 2'h2;
   localparam logic [1:0] RATIO_RSVD = 2'h3;
   localparam logic [1:0] RATIO_RESET = RATIO_QUARTER;
   localparam logic [1:0] RATIO_LSB = 2'h0;

   // Reset cause flag layout
   localparam int FLAG_POR = 0;
   localparam int FLAG_EXT = 1;
   localparam int FLAG_WDT = 2;
   localparam int FLAG_BOD = 3;
   localparam int FLAG_W = 4;
   localparam logic [3:0] FLAGS_AFTER_POR = 4'h1;

   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int EXT_MIN_ASSERT_NS = 300;
   localparam int FILTER_CYCLES_RAW =
      (EXT_MIN_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CYCLES = (FILTER_CYCLES_RAW < 1) ? 1 :
      FILTER_CYCLES_RAW;
   localparam int WAKE_CLOCKS = 4096;

   // Processor start address after release
   localparam logic [31:0] RESET_VECTOR = 32'h00000000;

   // Reset source inputs
   typedef struct packed {
      logic por;
      logic ext_n;
      logic wdt_timeout;
      logic watchdog_reset_enable;
      logic bod;
   } rsc_src_t;

   // One register access request
   typedef struct packed {
      logic sel;
      logic write;
      logic [31:0] addr;
      logic [7:0] wdata;
   } rsc_req_t;

   // Reset sequence states
   typedef enum logic [5:0] {
      ST_HOLD = 6'h01,
      ST_OSC = 6'h02,
      ST_WAKE = 6'h04,
      ST_INIT = 6'h08,
      ST_SETTLE = 6'h10,
      ST_RUN = 6'h20
   } rsc_state_t;

   // Terminal divider count for a ratio code
   function automatic logic [1:0] rsc_ratio_last(input logic [1:0] r);
      case (r)
         RATIO_FULL: rsc_ratio_last = 2'h0;
         RATIO_HALF: rsc_ratio_last = 2'h1;
         default: rsc_ratio_last = 2'h3;
      endcase
   endfunction

endpackage

// >>> rtl/rsc_sequencer.sv
// Reset sequencer, reset cause flags and peripheral clock ratio register
`timescale 1ns/10ps

module rsc_sequencer
   import rsc_pkg::*;
#(
   parameter int CFG_W = 2,
   parameter int WAKE_COUNT = WAKE_CLOCKS,
   parameter int FILTER_LEN = FILTER_CYCLES
) (
   // Clock, reset and freeze
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Reset sources
   input wire rsc_src_t src,
   // Oscillator, initialisation and flash status
   input wire logic osc_running,
   input wire logic init_done,
   input wire logic flash_busy,
   input wire logic flash_hv_settled,
   // Configuration pins
   input wire logic [CFG_W-1:0] cfg_pins,
   // Register port
   input wire rsc_req_t req,
   output logic [REG_W-1:0] reg_rdata,
   output logic reg_ack,
   // Reset and start-up outputs
   output logic sys_reset_n,
   output logic init_enable,
   output logic fetch_start,
   output logic [31:0] fetch_addr,
   output logic flash_abort,
   output logic [CFG_W-1:0] cfg_latched,
   // Peripheral clock
   output logic pclk_tick
);

   localparam int WAKE_W = $clog2(WAKE_COUNT + 1);
   localparam int FILT_W = $clog2(FILTER_LEN + 1);
   localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_COUNT - 1);
   localparam logic [FILT_W-1:0] FILT_FULL = FILT_W'(FILTER_LEN);

   initial begin
      if (WAKE_COUNT < 1 || FILTER_LEN < 1 || CFG_W < 1) begin
         $error("rsc_sequencer: counts and widths must be positive");
      end
   end

   rsc_state_t state;
   rsc_state_t next_state;
   logic [WAKE_W-1:0] wake_cnt;
   logic [WAKE_W-1:0] next_wake_cnt;
   logic [FILT_W-1:0] ext_cnt;
   logic [FILT_W-1:0] next_ext_cnt;
   logic ext_active;
   logic next_ext_active;
   logic abort_pending;
   logic next_abort_pending;
   logic [CFG_W-1:0] next_cfg_latched;
   logic [FLAG_W-1:0] flags;
   logic [FLAG_W-1:0] next_flags;
   logic [1:0] ratio;
   logic [1:0] next_ratio;
   logic [REG_W-1:0] next_rdata;
   logic wdt_evt;
   logic any_reset;
   logic hold_level;
   logic wr_flags;
   logic wr_ratio;

   // Reset requests seen this cycle, and register write strobes
   assign wdt_evt = src.wdt_timeout & src.watchdog_reset_enable;
   assign hold_level = src.por | ext_active | src.bod;
   assign any_reset = hold_level | wdt_evt;
   assign wr_flags = req.sel & req.write & (req.addr == ADDR_FLAGS);
   assign wr_ratio = req.sel & req.write & (req.addr == ADDR_RATIO);

   // Pin filter: low must last the full window, shorter dips vanish
   always_comb begin
      next_ext_cnt = '0;
      next_ext_active = 1'b0;
      if (!src.ext_n) begin
         next_ext_cnt = (ext_cnt == FILT_FULL) ? ext_cnt : ext_cnt + 1'b1;
         next_ext_active = (next_ext_cnt == FILT_FULL);
      end
   end

   // Sequence from reset through oscillator, wake count, init, flash
   always_comb begin
      next_state = state;
      next_wake_cnt = wake_cnt;
      next_abort_pending = abort_pending;
      if (any_reset && flash_busy) begin
         next_abort_pending = 1'b1;
      end
      if (any_reset) begin
         next_state = ST_HOLD;
         next_wake_cnt = '0;
      end else begin
         unique case (state)
            ST_HOLD: begin
               next_state = ST_OSC;
            end
            ST_OSC: begin
               if (osc_running) begin
                  next_state = ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (wake_cnt == WAKE_LAST) begin
                  next_state = ST_INIT;
               end else begin
                  next_wake_cnt = wake_cnt + 1'b1;
               end
            end
            ST_INIT: begin
               if (init_done) begin
                  next_state = ST_SETTLE;
               end
            end
            ST_SETTLE: begin
               // After an abort, release waits for flash high voltage to decay
               if (!abort_pending || flash_hv_settled) begin
                  next_state = ST_RUN;
                  next_abort_pending = 1'b0;
               end
            end
            ST_RUN: begin
               next_state = ST_RUN;
            end
            default: begin
               next_state = ST_HOLD;
            end
         endcase
      end
   end

   // Config pins reload only when the pin reset is released
   always_comb begin
      next_cfg_latched = cfg_latched;
      if (ext_active && !next_ext_active) begin
         next_cfg_latched = cfg_pins;
      end
   end

   // Cause flags; a hardware set wins over a same-cycle clear
   always_comb begin
      next_flags = flags;
      if (wr_flags) begin
         next_flags = flags & ~req.wdata[FLAG_W-1:0];
      end
      if (src.por) begin
         next_flags = FLAGS_AFTER_POR;
      end else begin
         if (ext_active) begin
            next_flags[FLAG_EXT] = 1'b1;
            next_flags[FLAG_WDT] = 1'b0;
         end
         if (src.bod) begin
            next_flags[FLAG_BOD] = 1'b1;
            next_flags[FLAG_WDT] = 1'b0;
         end
         if (wdt_evt) begin
            next_flags[FLAG_WDT] = 1'b1;
         end
      end
   end

   // Ratio register keeps its old value on the reserved code
   always_comb begin
      next_ratio = ratio;
      if (wr_ratio && req.wdata[1:0] != RATIO_RSVD) begin
         next_ratio = req.wdata[1:0];
      end
   end

   // Read data; reserved bits return zero
   always_comb begin
      next_rdata = '0;
      if (req.sel && !req.write) begin
         if (req.addr == ADDR_FLAGS) begin
            next_rdata[FLAG_W-1:0] = flags;
         end else if (req.addr == ADDR_RATIO) begin
            next_rdata[1:0] = ratio;
         end
      end
   end

   // State registers, all frozen while ce is low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_HOLD;
         wake_cnt <= '0;
         ext_cnt <= '0;
         ext_active <= 1'b0;
         abort_pending <= 1'b0;
         cfg_latched <= '0;
         flags <= FLAGS_AFTER_POR;
         ratio <= RATIO_RESET;
         reg_rdata <= '0;
         reg_ack <= 1'b0;
         sys_reset_n <= 1'b0;
         init_enable <= 1'b0;
         fetch_start <= 1'b0;
         fetch_addr <= RESET_VECTOR;
         flash_abort <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         wake_cnt <= next_wake_cnt;
         ext_cnt <= next_ext_cnt;
         ext_active <= next_ext_active;
         abort_pending <= next_abort_pending;
         cfg_latched <= next_cfg_latched;
         flags <= next_flags;
         ratio <= next_ratio;
         reg_rdata <= next_rdata;
         reg_ack <= req.sel;
         sys_reset_n <= (next_state == ST_RUN);
         init_enable <= (next_state == ST_INIT);
         fetch_start <= (next_state == ST_RUN) && (state != ST_RUN);
         fetch_addr <= RESET_VECTOR;
         flash_abort <= next_abort_pending;
      end
   end

   // Divider on the undivided processor clock
   rsc_pclk_div #(
      .CNT_W(2)
   ) u_div (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .ratio(ratio),
      .pclk_tick(pclk_tick),
      .active()
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_release_in_run: assert property (sys_reset_n |-> state == ST_RUN)
      else $error("reset released outside run state");
   a_wake_full_count: assert property (
      (state == ST_WAKE && next_state == ST_INIT) |->
      wake_cnt == WAKE_LAST)
      else $error("wake count ended early");
   a_filter_length: assert property ($rose(ext_active) |->
      ext_cnt == FILT_FULL && $past(!src.ext_n))
      else $error("pin reset accepted before filter window");
   a_fetch_vector: assert property ($rose(sys_reset_n) |->
      fetch_start && fetch_addr == RESET_VECTOR)
      else $error("release without start at vector");
   a_cfg_internal: assert property (!$past(ext_active) |->
      $stable(cfg_latched))
      else $error("config latch changed without pin reset");
   a_flash_hold: assert property (
      (abort_pending && !flash_hv_settled) |=> !sys_reset_n)
      else $error("release while flash voltage unsettled");
   a_flag_clear: assert property ((ce && wr_flags &&
      req.wdata[FLAG_POR] && !src.por) |=> !flags[FLAG_POR])
      else $error("write one failed to clear flag");
   a_por_flags: assert property ((ce && src.por) |=>
      flags == FLAGS_AFTER_POR)
      else $error("power-on flag pattern wrong");
   a_ext_flag: assert property ((ce && ext_active && !src.por) |=>
      flags[FLAG_EXT])
      else $error("pin reset flag not set");
   a_wdt_flag: assert property ((ce && wdt_evt && !src.por) |=>
      flags[FLAG_WDT])
      else $error("watchdog flag not set");
   a_bod_flag: assert property ((ce && src.bod && !src.por) |=>
      flags[FLAG_BOD])
      else $error("brown-out flag not set");
   a_ratio_rsvd: assert property ((wr_ratio &&
      req.wdata[1:0] == RATIO_RSVD) |=> $stable(ratio))
      else $error("reserved ratio code took effect");

   c_reach_run: cover property ($rose(sys_reset_n));
   c_flash_abort: cover property ($rose(flash_abort));
   c_ratio_half: cover property (wr_ratio && req.wdata[1:0] == RATIO_HALF);
   c_wdt_reset: cover property (wdt_evt && !src.por);

endmodule

// >>> test/reset_source_and_pclk_divider_tb_top.sv
// Self-checking bench for the reset sequencer and clock divider
`timescale 1ns/10ps
module reset_source_and_pclk_divider_tb_top;
   import rsc_pkg::*;
   localparam int WAKE_N = 8;
   logic clk, nrst, ce, por, wdt, wen, bod, flash_busy, hv, pin_go;
   logic ext_n, osc_running, init_done;
   logic [7:0] pin_len, q;
   logic [1:0] cfg, cfg_old, r;
   rsc_src_t src;
   rsc_req_t req;
   logic [7:0] reg_rdata;
   logic reg_ack, sys_reset_n, init_enable, fetch_start, flash_abort;
   logic pclk_tick, saw;
   logic [31:0] fetch_addr;
   logic [1:0] cfg_latched;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed, n, p, i;

   assign src = {por, ext_n, wdt, wen, bod};

   rsc_sequencer #(.WAKE_COUNT(WAKE_N)) DUT (.clk(clk), .nrst(nrst),
      .ce(ce), .src(src), .osc_running(osc_running),
      .init_done(init_done), .flash_busy(flash_busy),
      .flash_hv_settled(hv), .cfg_pins(cfg), .req(req),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .sys_reset_n(sys_reset_n),
      .init_enable(init_enable), .fetch_start(fetch_start),
      .fetch_addr(fetch_addr), .flash_abort(flash_abort),
      .cfg_latched(cfg_latched), .pclk_tick(pclk_tick));

   rsc_board_model board (.clk(clk), .pin_go(pin_go), .pin_len(pin_len),
      .init_enable(init_enable), .ext_n(ext_n),
      .osc_running(osc_running), .init_done(init_done));

   // 10 MHz processor clock
   initial begin
      clk = 1'b0;
      forever #50 clk = !clk;
   end

   task automatic close_out;
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Tick spacing that each ratio code should give
   function automatic int exp_period(input logic [1:0] code);
      case (code)
         2'h1: exp_period = 1;
         2'h2: exp_period = 2;
         default: exp_period = 4;
      endcase
   endfunction

   task automatic step;
      @(posedge clk);
      #1;
   endtask

   // One register access: request for one edge, answer at the next
   task automatic reg_acc(input logic w, input logic [31:0] a,
                          input logic [7:0] d, output logic [7:0] rd);
      @(posedge clk);
      req <= '{1'b1, w, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, 32'h0, 8'h0};
      #1;
      rd = reg_rdata;
      chk("reg_ack", 32'(ce), reg_ack);
   endtask

   task automatic wait_tick;
      int k;
      k = 0;
      while (pclk_tick !== 1'b1 && k < 20) begin
         step();
         k++;
      end
      if (k >= 20) begin
         n_mismatch++;
         close_out();
      end
   endtask

   // Skip one period so a new ratio is in force, then measure
   task automatic tick_period(output int per);
      wait_tick();
      step();
      wait_tick();
      per = 0;
      do begin
         step();
         per++;
      end while (pclk_tick !== 1'b1 && per < 20);
      if (pclk_tick !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask

   // Bounded wait for release; a hang ends the run
   task automatic wait_rel(output int cyc);
      cyc = 0;
      while (sys_reset_n !== 1'b1 && cyc < 300) begin
         step();
         cyc++;
      end
      chk("release", 32'h1, sys_reset_n);
      if (cyc >= 300)
         close_out();
      chk("fetch_start", 32'h1, fetch_start);
      chk("fetch_addr", 32'h0, fetch_addr);
   endtask

   // Board pulses the reset pin low for len cycles
   task automatic pin_pulse(input logic [7:0] len, output logic low);
      low = 1'b0;
      @(posedge clk);
      pin_go <= 1'b1;
      pin_len <= len;
      @(posedge clk);
      pin_go <= 1'b0;
      repeat (len + 4) begin
         step();
         low = low | (sys_reset_n === 1'b0);
      end
   endtask

   // Watchdog timeout held for one cycle
   task automatic wdt_hit;
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      repeat (4) step();
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      seed = 32'h1d77;
      {nrst, por, wdt, wen, bod, flash_busy, pin_go} = 7'h0;
      ce = 1'b1;
      hv = 1'b1;
      pin_len = 8'h0;
      req = '0;
      cfg = 2'($random(seed));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      tick_period(p);
      chk("quarter_rate", 32'h4, 32'(p));
      wait_rel(n);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("power_flags", 32'h3, q);
      reg_acc(1'b0, ADDR_RATIO, 8'h0, q);
      chk("ratio_reset", 32'h0, q);
      chk("cfg_power", cfg, cfg_latched);
      // Ratio codes 0 to 2 in turn, then random ones, each checked on the divided tick
      for (i = 0; i < 6; i++) begin
         r = (i < 3) ? 2'(i) : 2'({$random(seed)} % 3);
         reg_acc(1'b1, ADDR_RATIO, {6'h0, r}, q);
         reg_acc(1'b0, ADDR_RATIO, 8'h0, q);
         chk("ratio", r, q[1:0]);
         tick_period(p);
         chk("pclk_period", exp_period(r), p);
      end
      reg_acc(1'b1, ADDR_RATIO, 8'h03, q);
      reg_acc(1'b0, ADDR_RATIO, 8'h0, q);
      chk("ratio_rsvd", r, q[1:0]);
      tick_period(p);
      chk("rsvd_period", exp_period(r), p);
      // Clock enable low: divider frozen, a request is not taken
      @(posedge clk);
      ce <= 1'b0;
      step();
      saw = pclk_tick;
      reg_acc(1'b1, ADDR_RATIO, {6'h0, (r == 2'h1) ? 2'h2 : 2'h1}, q);
      repeat (4) step();
      chk("ce_tick", saw, pclk_tick);
      @(posedge clk);
      ce <= 1'b1;
      reg_acc(1'b0, ADDR_RATIO, 8'h0, q);
      chk("ce_refused", r, q[1:0]);
      reg_acc(1'b0, 32'he01fc104, 8'h0, q);
      chk("unmapped", 32'h0, q);
      reg_acc(1'b1, ADDR_FLAGS, 8'h0f, q);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("w1c_all", 32'h0, q);
      // Short pin glitch must not reset the chip
      pin_pulse(8'd2, saw);
      chk("glitch", 32'h0, saw);
      @(posedge clk);
      cfg <= 2'($random(seed));
      pin_pulse(8'd5, saw);
      chk("pin_reset", 32'h1, saw);
      wait_rel(n);
      chk("wake_span", 32'h1, n >= WAKE_N);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("ext_flag", 32'h2, q);
      chk("cfg_ext", cfg, cfg_latched);
      reg_acc(1'b1, ADDR_FLAGS, 8'h00, q);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("w0_keeps", 32'h2, q);
      // Disabled watchdog, then enabled one during a flash operation
      cfg_old = cfg;
      wdt_hit();
      chk("wdt_off", 32'h1, sys_reset_n);
      @(posedge clk);
      cfg <= ~cfg;
      wen <= 1'b1;
      flash_busy <= 1'b1;
      hv <= 1'b0;
      wdt_hit();
      chk("flash_abort", 32'h1, flash_abort);
      repeat (40) step();
      chk("hv_hold", 32'h0, sys_reset_n);
      @(posedge clk);
      hv <= 1'b1;
      flash_busy <= 1'b0;
      wen <= 1'b0;
      wait_rel(n);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("wdt_flag", 32'h6, q);
      chk("cfg_int", cfg_old, cfg_latched);
      // Brown-out clears the watchdog flag, keeps the pin flag
      @(posedge clk);
      bod <= 1'b1;
      repeat (5) @(posedge clk);
      bod <= 1'b0;
      wait_rel(n);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("bod_flag", 32'ha, q);
      @(posedge clk);
      por <= 1'b1;
      repeat (5) @(posedge clk);
      por <= 1'b0;
      wait_rel(n);
      reg_acc(1'b0, ADDR_FLAGS, 8'h0, q);
      chk("por_flag", 32'h1, q);
      close_out();
   end
endmodule

// >>> test/rsc_board_model.sv
// Board-side model: reset pin pulser, oscillator and init completion
`timescale 1ns/10ps
module rsc_board_model
   import rsc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Pin pulse command and its length in cycles
   input wire logic pin_go,
   input wire logic [7:0] pin_len,
   // Sequencer status
   input wire logic init_enable,
   // Board outputs
   output logic ext_n,
   output logic osc_running,
   output logic init_done
);
   int low_left = 0;
   int osc_wait = 20;
   int init_wait = 0;
   logic slow = 1'b0;

   initial begin
      ext_n = 1'b0;
      osc_running = 1'b0;
      init_done = 1'b0;
   end

   // Pin held low past oscillator start at power-up, then short pulses
   always @(posedge clk) begin
      if (osc_wait > 0)
         osc_wait <= osc_wait - 1;
      osc_running <= (osc_wait < 10);
      if (pin_go)
         low_left <= pin_len;
      else if (low_left > 0)
         low_left <= low_left - 1;
      ext_n <= !(osc_wait > 0 || pin_go || low_left > 1);
   end

   // Init finishes promptly or slowly, alternating between sequences
   always @(posedge clk) begin
      if (!init_enable) begin
         init_done <= 1'b0;
         init_wait <= slow ? 5 : 0;
      end else if (init_wait > 0) begin
         init_wait <= init_wait - 1;
      end else begin
         init_done <= 1'b1;
      end
      if (init_enable && init_done)
         slow <= !slow;
   end
endmodule
